// file: rtl/accumulator_transfer_decode.v
// Accumulator transfer decoder with destination registers and APB view
//
// Design decisions made here: register access over APB and the register offsets.
`include "acc_xfer_consts.vh"

module accumulator_transfer_decode #(
    parameter       DATA_WIDTH   = 4,
    parameter       PTR_WIDTH    = 6,
    parameter [9:0] OP_WAKEUP_2  = `OP_WAKEUP_TWO,
    parameter [9:0] OP_DISPLAY_1 = `OP_DISPLAY_ONE
) (
    input  wire                  ref_clk,
    input  wire                  reset,
    // Instruction stream from the core
    input  wire                  instr_valid,
    input  wire [9:0]            instr_code,
    input  wire [DATA_WIDTH-1:0] acc,
    input  wire [PTR_WIDTH-1:0]  ram_pointer,
    input  wire                  col_ptr_wr,
    input  wire [DATA_WIDTH-1:0] col_ptr_in,
    // Destination registers
    output wire [DATA_WIDTH-1:0] wakeup_ctrl_two,
    output wire [DATA_WIDTH-1:0] wakeup_ctrl_three,
    output wire [DATA_WIDTH-1:0] display_ctrl_one,
    output wire [DATA_WIDTH-1:0] display_ctrl_two,
    output wire [DATA_WIDTH-1:0] display_ctrl_three,
    output wire [DATA_WIDTH-1:0] display_clock_timer,
    output wire [DATA_WIDTH-1:0] timer_reload_value,
    output wire [DATA_WIDTH-1:0] clock_setting_reg,
    output reg  [DATA_WIDTH-1:0] col_ptr_q,
    // Data memory write port
    output reg                   ram_wr_q,
    output reg  [PTR_WIDTH-1:0]  ram_addr_q,
    output reg  [DATA_WIDTH-1:0] ram_wdata_q,
    // APB slave
    input  wire                  psel,
    input  wire                  penable,
    input  wire                  pwrite,
    input  wire [11:0]           paddr,
    input  wire [31:0]           pwdata,
    output reg  [31:0]           prdata,
    output reg                   pready,
    output reg                   pslverr
);

    // -----------------------------------------------------------------
    // Instruction decode
    // -----------------------------------------------------------------
    reg                    decode_en_q;
    reg [`STAT_WIDTH-1:0]  stat_q;
    wire                   go = instr_valid && decode_en_q;

    wire hit_k2    = go && (instr_code == OP_WAKEUP_2);
    wire hit_k3    = go && (instr_code == `OP_WAKEUP_THREE);
    wire hit_l1    = go && (instr_code == OP_DISPLAY_1);
    wire hit_l2    = go && (instr_code == `OP_DISPLAY_TWO);
    wire hit_l3    = go && (instr_code == `OP_DISPLAY_THREE);
    wire hit_timer = go && (instr_code == `OP_DISPLAY_TIMER);
    wire hit_clock = go && (instr_code == `OP_CLOCK_CTRL);
    wire hit_store = go && ((instr_code & `OP_STORE_MASK) == `OP_STORE_BASE);
    wire [3:0] imm_j = instr_code[3:0];

    // -----------------------------------------------------------------
    // Destination registers, each loaded by its own transfer; the timer transfer loads both timer and reload
    // -----------------------------------------------------------------
    wire [7:0] loads = {hit_clock, hit_timer, hit_timer, hit_l3, hit_l2, hit_l1, hit_k3, hit_k2};
    wire [DATA_WIDTH-1:0] dest [0:7];

    // One holding register per destination, all fed from the accumulator
    acc_load_reg #(
        .WIDTH   (DATA_WIDTH)
    ) u_wakeup_two (
        .ref_clk (ref_clk),
        .reset   (reset),
        .load    (loads[0]),
        .value   (acc),
        .data_q  (dest[0])
    );

    acc_load_reg #(
        .WIDTH   (DATA_WIDTH)
    ) u_wakeup_three (
        .ref_clk (ref_clk),
        .reset   (reset),
        .load    (loads[1]),
        .value   (acc),
        .data_q  (dest[1])
    );

    acc_load_reg #(
        .WIDTH   (DATA_WIDTH)
    ) u_display_one (
        .ref_clk (ref_clk),
        .reset   (reset),
        .load    (loads[2]),
        .value   (acc),
        .data_q  (dest[2])
    );

    acc_load_reg #(
        .WIDTH   (DATA_WIDTH)
    ) u_display_two (
        .ref_clk (ref_clk),
        .reset   (reset),
        .load    (loads[3]),
        .value   (acc),
        .data_q  (dest[3])
    );

    acc_load_reg #(
        .WIDTH   (DATA_WIDTH)
    ) u_display_three (
        .ref_clk (ref_clk),
        .reset   (reset),
        .load    (loads[4]),
        .value   (acc),
        .data_q  (dest[4])
    );

    acc_load_reg #(
        .WIDTH   (DATA_WIDTH)
    ) u_timer (
        .ref_clk (ref_clk),
        .reset   (reset),
        .load    (loads[5]),
        .value   (acc),
        .data_q  (dest[5])
    );

    acc_load_reg #(
        .WIDTH   (DATA_WIDTH)
    ) u_reload (
        .ref_clk (ref_clk),
        .reset   (reset),
        .load    (loads[6]),
        .value   (acc),
        .data_q  (dest[6])
    );

    acc_load_reg #(
        .WIDTH   (DATA_WIDTH)
    ) u_clock (
        .ref_clk (ref_clk),
        .reset   (reset),
        .load    (loads[7]),
        .value   (acc),
        .data_q  (dest[7])
    );

    assign wakeup_ctrl_two     = dest[0];
    assign wakeup_ctrl_three   = dest[1];
    assign display_ctrl_one    = dest[2];
    assign display_ctrl_two    = dest[3];
    assign display_ctrl_three  = dest[4];
    assign display_clock_timer = dest[5];
    assign timer_reload_value  = dest[6];
    assign clock_setting_reg   = dest[7];

    // -----------------------------------------------------------------
    // Memory store and column pointer update
    // -----------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (reset) begin
            ram_wr_q    <= 1'b0;
            ram_addr_q  <= {PTR_WIDTH{1'b0}};
            ram_wdata_q <= `NIBBLE_RESET;
            col_ptr_q   <= `NIBBLE_RESET;
        end else begin
            ram_wr_q <= hit_store;
            if (hit_store) begin
                ram_addr_q  <= ram_pointer;
                ram_wdata_q <= acc;
                col_ptr_q   <= col_ptr_q ^ imm_j[DATA_WIDTH-1:0];
            end else if (col_ptr_wr) begin
                col_ptr_q   <= col_ptr_in;
            end
        end
    end

    // Status: one bit per transfer seen, sticky until written
    wire [`STAT_WIDTH-1:0] stat_set = {hit_store, hit_clock, hit_timer, hit_l3, hit_l2, hit_l1, hit_k3, hit_k2};

    // -----------------------------------------------------------------
    // APB slave, no wait state: answer in the first access cycle
    // -----------------------------------------------------------------
    wire setup    = psel && !penable;
    wire access   = psel && penable && pready;
    wire wr_ctrl  = access && pwrite && (paddr == `ADDR_DECODE_CTRL);
    wire wr_stat  = access && pwrite && (paddr == `ADDR_DECODE_STAT);

    reg [31:0] rd_d;
    reg        err_d;

    // Read decode
    always @* begin
        rd_d  = 32'h0000_0000;
        err_d = 1'b0;
        if (paddr == `ADDR_WAKEUP_TWO) begin
            rd_d[DATA_WIDTH-1:0] = dest[0];
        end else if (paddr == `ADDR_WAKEUP_THREE) begin
            rd_d[DATA_WIDTH-1:0] = dest[1];
        end else if (paddr == `ADDR_DISPLAY_ONE) begin
            rd_d[DATA_WIDTH-1:0] = dest[2];
        end else if (paddr == `ADDR_DISPLAY_TWO) begin
            rd_d[DATA_WIDTH-1:0] = dest[3];
        end else if (paddr == `ADDR_DISPLAY_THREE) begin
            rd_d[DATA_WIDTH-1:0] = dest[4];
        end else if (paddr == `ADDR_TIMER) begin
            rd_d[DATA_WIDTH-1:0] = dest[5];
        end else if (paddr == `ADDR_RELOAD) begin
            rd_d[DATA_WIDTH-1:0] = dest[6];
        end else if (paddr == `ADDR_CLOCK_CTRL) begin
            rd_d[DATA_WIDTH-1:0] = dest[7];
        end else if (paddr == `ADDR_COL_PTR) begin
            rd_d[DATA_WIDTH-1:0] = col_ptr_q;
        end else if (paddr == `ADDR_DECODE_CTRL) begin
            rd_d[`CTRL_ENABLE_BIT] = decode_en_q;
        end else if (paddr == `ADDR_DECODE_STAT) begin
            rd_d[`STAT_WIDTH-1:0] = stat_q;
        end else begin
            err_d = 1'b1;
        end
    end

    // Bus response and software-visible control
    always @(posedge ref_clk) begin
        if (reset) begin
            pready      <= 1'b0;
            prdata      <= 32'h0000_0000;
            pslverr     <= 1'b0;
            decode_en_q <= `CTRL_RESET;
            stat_q      <= `STAT_RESET;
        end else begin
            pready  <= setup;
            pslverr <= setup && err_d;
            prdata  <= (setup && !pwrite) ? rd_d : 32'h0000_0000;
            if (wr_ctrl) begin
                decode_en_q <= pwdata[`CTRL_ENABLE_BIT];
            end
            // Set wins over a clear in the same cycle
            if (wr_stat) begin
                stat_q <= (stat_q & ~pwdata[`STAT_WIDTH-1:0]) | stat_set;
            end else begin
                stat_q <= stat_q | stat_set;
            end
        end
    end

endmodule // accumulator_transfer_decode

// file: rtl/acc_xfer_consts.vh
// Constants for the accumulator transfer decoder and its APB register window
`ifndef ACC_XFER_CONSTS_VH
`define ACC_XFER_CONSTS_VH

// -----------------------------------------------------------------
// Instruction codes
// -----------------------------------------------------------------
`define OP_WAKEUP_TWO      10'h22b
`define OP_WAKEUP_THREE    10'h22c
`define OP_DISPLAY_ONE     10'h20a
`define OP_DISPLAY_TWO     10'h20b
`define OP_DISPLAY_THREE   10'h20c
`define OP_DISPLAY_TIMER   10'h20d
`define OP_CLOCK_CTRL      10'h216
`define OP_STORE_BASE      10'h2b0
`define OP_STORE_MASK      10'h3f0

// -----------------------------------------------------------------
// APB byte offsets
// -----------------------------------------------------------------
`define ADDR_WAKEUP_TWO    12'h000
`define ADDR_WAKEUP_THREE  12'h004
`define ADDR_DISPLAY_ONE   12'h008
`define ADDR_DISPLAY_TWO   12'h00c
`define ADDR_DISPLAY_THREE 12'h010
`define ADDR_TIMER         12'h014
`define ADDR_RELOAD        12'h018
`define ADDR_CLOCK_CTRL    12'h01c
`define ADDR_COL_PTR       12'h020
`define ADDR_DECODE_CTRL   12'h024
`define ADDR_DECODE_STAT   12'h028

// -----------------------------------------------------------------
// Field layouts and reset values
// -----------------------------------------------------------------
`define CTRL_ENABLE_BIT    0
`define CTRL_RESET         1'h1
`define NIBBLE_RESET       4'h0
`define STAT_RESET         8'h00
`define STAT_WIDTH         8

`endif

// file: rtl/acc_load_reg.v
// Four-bit destination register loaded from the accumulator
module acc_load_reg #(
    parameter WIDTH = 4
) (
    input  wire             ref_clk,
    input  wire             reset,
    input  wire             load,
    input  wire [WIDTH-1:0] value,
    output reg  [WIDTH-1:0] data_q
);

    // Hold value until a transfer names this register
    always @(posedge ref_clk) begin
        if (reset) begin
            data_q <= {WIDTH{1'b0}};
        end else if (load) begin
            data_q <= value;
        end
    end

endmodule // acc_load_reg

// file: sim/acc_xfer_monitor.sv
// Checker bound to the accumulator transfer decoder
`include "acc_xfer_consts.vh"
module acc_xfer_monitor #(
    parameter [9:0] OP_WAKEUP_2  = `OP_WAKEUP_TWO,
    parameter [9:0] OP_DISPLAY_1 = `OP_DISPLAY_ONE
) (
    input wire        ref_clk,
    input wire        reset,
    input wire        instr_valid,
    input wire        col_ptr_wr,
    input wire        ram_wr_q,
    input wire [9:0]  instr_code,
    input wire [5:0]  ram_pointer,
    input wire [5:0]  ram_addr_q,
    input wire [3:0]  acc,
    input wire [3:0]  col_ptr_q,
    input wire [3:0]  ram_wdata_q,
    input wire [3:0]  wakeup_ctrl_two,
    input wire [3:0]  wakeup_ctrl_three,
    input wire [3:0]  display_ctrl_one,
    input wire [3:0]  display_ctrl_two,
    input wire [3:0]  display_ctrl_three,
    input wire [3:0]  display_clock_timer,
    input wire [3:0]  timer_reload_value,
    input wire [3:0]  clock_setting_reg,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire        pready,
    input wire [11:0] paddr,
    input wire [31:0] pwdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // Decode enable as software last wrote it over the bus
    logic en_q;
    always @(posedge ref_clk) begin
        if (reset) begin
            en_q <= 1'b1;
        end else if (psel && penable && pready && pwrite && paddr == `ADDR_DECODE_CTRL) begin
            en_q <= pwdata[`CTRL_ENABLE_BIT];
        end
    end
    // Decoded strobes, refused while decode is off
    wire       v  = instr_valid && en_q;
    wire [3:0] j  = instr_code[3:0];
    wire       st = v && (instr_code & `OP_STORE_MASK) == `OP_STORE_BASE;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    property p_w2; v && instr_code == OP_WAKEUP_2 |=> wakeup_ctrl_two == $past(acc); endproperty
    a_w2: assert property (p_w2) else $error("wakeup two bad");
    property p_w3; v && instr_code == `OP_WAKEUP_THREE |=> wakeup_ctrl_three == $past(acc); endproperty
    a_w3: assert property (p_w3) else $error("wakeup three bad");
    property p_d1; v && instr_code == OP_DISPLAY_1 |=> display_ctrl_one == $past(acc); endproperty
    a_d1: assert property (p_d1) else $error("display one bad");
    property p_d2; v && instr_code == `OP_DISPLAY_TWO |=> display_ctrl_two == $past(acc); endproperty
    a_d2: assert property (p_d2) else $error("display two bad");
    property p_d3; v && instr_code == `OP_DISPLAY_THREE |=> display_ctrl_three == $past(acc); endproperty
    a_d3: assert property (p_d3) else $error("display three bad");
    property p_tm; v && instr_code == `OP_DISPLAY_TIMER |=> display_clock_timer == $past(acc)
        && timer_reload_value == $past(acc); endproperty
    a_tm: assert property (p_tm) else $error("timer pair bad");
    property p_ck; v && instr_code == `OP_CLOCK_CTRL |=> clock_setting_reg == $past(acc); endproperty
    a_ck: assert property (p_ck) else $error("clock reg bad");
    property p_st; st |=> ram_wr_q && ram_addr_q == $past(ram_pointer) && ram_wdata_q == $past(acc)
        && col_ptr_q == ($past(col_ptr_q) ^ $past(j)); endproperty
    a_st: assert property (p_st) else $error("store bad");
    property p_nw; !st |=> !ram_wr_q; endproperty
    a_nw: assert property (p_nw) else $error("stray write");
    property p_kp; v && instr_code == `OP_DISPLAY_TWO && !col_ptr_wr |=> $stable(wakeup_ctrl_two)
        && $stable(clock_setting_reg) && $stable(col_ptr_q) && !ram_wr_q; endproperty
    a_kp: assert property (p_kp) else $error("side effect");
    // Main scenarios
    c_st: cover property (col_ptr_wr ##1 st);
    c_tm: cover property (v && instr_code == `OP_DISPLAY_TIMER);
    c_bb: cover property (v ##1 v ##1 v);
    c_off: cover property (instr_valid && !en_q);
endmodule // acc_xfer_monitor

bind accumulator_transfer_decode acc_xfer_monitor #(.OP_WAKEUP_2(OP_WAKEUP_2), .OP_DISPLAY_1(OP_DISPLAY_1)) i_mon (.*);

// file: sim/tb_accumulator_transfer_decode.sv
// Self-checking bench for the accumulator transfer decoder
`include "acc_xfer_consts.vh"
module tb_accumulator_transfer_decode;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk = 0, reset = 1, instr_valid = 0, col_ptr_wr = 0, psel = 0, penable = 0, pwrite = 0;
    logic [9:0]  instr_code = '0;
    logic [3:0]  acc = '0, col_ptr_in = '0;
    logic [5:0]  ram_pointer = '0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, r;
    logic        e;
    wire  [3:0]  wakeup_ctrl_two, wakeup_ctrl_three, display_ctrl_one, display_ctrl_two, display_ctrl_three;
    wire  [3:0]  display_clock_timer, timer_reload_value, clock_setting_reg, col_ptr_q, ram_wdata_q;
    wire  [5:0]  ram_addr_q;
    wire  [31:0] prdata;
    wire         ram_wr_q, pready, pslverr;
    int          n_errors = 0, cmp_count = 0;
    accumulator_transfer_decode i_dut (.*);
    // Clock
    always #2.5 ref_clk = ~ref_clk;
    // Compare and report
    task chk(input [31:0] g, input [31:0] x);
        cmp_count++;
        if (g !== x) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, g, x);
        end
    endtask
    // One APB transfer, released only after pready is seen
    task apb(input w, input [11:0] a, input [31:0] d);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge ref_clk);
        penable <= 1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        r = prdata; e = pslverr; psel <= 0; penable <= 0;
        @(posedge ref_clk);
    endtask
    task rd(input [11:0] a, input [31:0] x, input xe);
        apb(0, a, 32'h0);
        chk(r, x);
        chk(32'(e), 32'(xe));
    endtask
    // Back to back loads, each to its own destination, the timer code to both timer and reload
    task t_loads;
        logic [9:0] tbl [7];
        tbl = '{`OP_WAKEUP_TWO, `OP_WAKEUP_THREE, `OP_DISPLAY_ONE, `OP_DISPLAY_TWO,
                `OP_DISPLAY_THREE, `OP_DISPLAY_TIMER, `OP_CLOCK_CTRL};
        for (int i = 0; i < 7; i++) begin
            instr_valid <= 1; instr_code <= tbl[i]; acc <= 4'(i + 1);
            @(posedge ref_clk);
        end
        instr_valid <= 0;
        @(negedge ref_clk);
        chk(32'(wakeup_ctrl_two), 32'h1);
        chk(32'(wakeup_ctrl_three), 32'h2);
        chk(32'(display_ctrl_one), 32'h3);
        chk(32'(display_ctrl_two), 32'h4);
        chk(32'(display_ctrl_three), 32'h5);
        chk(32'({display_clock_timer, timer_reload_value}), 32'h66);
        chk(32'(clock_setting_reg), 32'h7);
        chk(32'({col_ptr_q, ram_wr_q}), 32'h0);
        @(posedge ref_clk);
        apb(1, `ADDR_DISPLAY_TWO, 32'hf);
        rd(`ADDR_DISPLAY_TWO, 32'h4, 0);
    endtask
    // One store, then the write pulse must be gone
    task st(input [3:0] j, input [3:0] a, input [5:0] p, input [3:0] xc);
        instr_valid <= 1; instr_code <= `OP_STORE_BASE | 10'(j); acc <= a; ram_pointer <= p;
        @(posedge ref_clk);
        instr_valid <= 0;
        @(negedge ref_clk);
        chk(32'({ram_wr_q, ram_addr_q, ram_wdata_q, col_ptr_q}), 32'({1'b1, p, a, xc}));
        @(negedge ref_clk);
        chk(32'(ram_wr_q), 32'h0);
        @(posedge ref_clk);
    endtask
    task t_store;
        col_ptr_wr <= 1; col_ptr_in <= 4'h5;
        @(posedge ref_clk);
        col_ptr_wr <= 0;
        st(4'hf, 4'h9, 6'h2a, 4'ha);
        st(4'h0, 4'h3, 6'h15, 4'ha);
        st(4'h5, 4'hc, 6'h3f, 4'hf);
        rd(`ADDR_DECODE_STAT, 32'hff, 0);
        apb(1, `ADDR_DECODE_STAT, 32'hff);
        rd(`ADDR_DECODE_STAT, 32'h0, 0);
        rd(12'h100, 32'h0, 1);
    endtask
    // Unknown code and decode switched off: nothing may change
    task t_refused;
        instr_valid <= 1;
        instr_code <= 10'h3ff;
        acc <= 4'he;
        @(posedge ref_clk);
        instr_valid <= 0;
        apb(1, `ADDR_DECODE_CTRL, 32'h0);
        rd(`ADDR_DECODE_CTRL, 32'h0, 0);
        instr_valid <= 1;
        instr_code <= `OP_DISPLAY_TWO;
        @(posedge ref_clk);
        instr_code <= `OP_STORE_BASE | 10'h3;
        @(posedge ref_clk);
        instr_valid <= 0;
        @(negedge ref_clk);
        chk(32'({display_ctrl_two, ram_wr_q, col_ptr_q}), 32'({4'h4, 1'b0, 4'hf}));
        @(posedge ref_clk);
        rd(`ADDR_DECODE_STAT, 32'h0, 0);
        apb(1, `ADDR_DECODE_CTRL, 32'h1);
        rd(`ADDR_DECODE_CTRL, 32'h1, 0);
        rd(`ADDR_COL_PTR, 32'hf, 0);
    endtask
    // Verdict
    task summarize;
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (8) @(posedge ref_clk);
        reset <= 0;
        @(posedge ref_clk);
        t_loads;
        t_store;
        t_refused;
        summarize;
    end
    // Watchdog
    initial begin
        #20000;
        n_errors++;
        $display("[FAIL] %0t timeout", $time);
        summarize;
    end
endmodule // tb_accumulator_transfer_decode
